// File: design/sbst_pkg.sv
`default_nettype none
package sbst_pkg;
  // ==========================================================
  // scan register sizes
  localparam int IR_W = 3;
  localparam int ID_W = 32;
  localparam int BSR_LEN = 71;
  // ==========================================================
  // instruction codes
  localparam logic [IR_W-1:0] INS_EXTEST = 3'h0;
  localparam logic [IR_W-1:0] INS_IDCODE = 3'h1;
  localparam logic [IR_W-1:0] INS_SAMPZ = 3'h2;
  localparam logic [IR_W-1:0] INS_SAMPLE = 3'h4;
  localparam logic [IR_W-1:0] INS_BYPASS = 3'h7;
  localparam logic [IR_W-1:0] IR_CAP_VAL = 3'h1;
  localparam logic [1:0] IR_CAP_PATTERN = 2'h1;
  // ==========================================================
  // identification fields, defaults; device and maker codes arbitrary
  localparam logic [2:0] ID_REV_DEF = 3'h0;
  localparam logic [4:0] ID_DEPTH_DEF = 5'h0b;
  localparam logic [5:0] ID_WIDTH_DEF = 6'h29;
  localparam logic [5:0] ID_DEV_DEF = 6'h2a;
  localparam logic [10:0] ID_MAKER_DEF = 11'h155;
  localparam logic ID_PRESENT = 1'h1;
  // ==========================================================
  // timing
  localparam int CORE_CLK_NS = 50;
  localparam int TCK_MIN_CYCLE_NS = 50;
  localparam int TMS_RESET_RISES = 5;
  localparam int SYNC_STAGES = 2;
  // ==========================================================
  // register map
  localparam int AXI_ADDR_W = 4;
  localparam logic [AXI_ADDR_W-1:0] REG_CTRL = 4'h0;
  localparam logic [AXI_ADDR_W-1:0] REG_STATUS = 4'h4;
  localparam logic [AXI_ADDR_W-1:0] REG_IDVAL = 4'h8;
  localparam int CTRL_HOLD_BIT = 0;
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_IR_LSB = 4;
  localparam int STAT_HIZ_BIT = 8;
  localparam int STAT_DRIVE_BIT = 9;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ==========================================================
  // controller states
  typedef enum logic [3:0] {
    ST_TLR, ST_RTI, ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR, ST_PA_DR, ST_EX2_DR,
    ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SH_IR, ST_EX1_IR, ST_PA_IR, ST_EX2_IR, ST_UPD_IR
  } sbst_state_e;
endpackage : sbst_pkg
`default_nettype wire

// File: design/sbst_sync.sv
`timescale 1ns/10ps
`default_nettype none
module sbst_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q;
  logic [W-1:0] sync_d;

  always_comb begin
    meta_d = din;
    sync_d = meta_q;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign dout = sync_q;
endmodule : sbst_sync
`default_nettype wire

// File: design/sbst_shreg.sv
`timescale 1ns/10ps
`default_nettype none
// capture or shift right, serial in at the msb
module sbst_shreg #(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic cap,
  input wire logic shift,
  input wire logic [W-1:0] cap_val,
  input wire logic sin,
  output logic [W-1:0] q
);
  logic [W-1:0] sh_q;
  logic [W-1:0] sh_d;

  always_comb begin
    sh_d = sh_q;
    if (cap) begin
      sh_d = cap_val;
    end else if (shift) begin
      // same form for a one-bit register
      sh_d = (sh_q >> 1) | (W'(sin) << (W - 1));
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sh_q <= '0;
    end else begin
      sh_q <= sh_d;
    end
  end

  assign q = sh_q;
endmodule : sbst_shreg
`default_nettype wire

// File: design/sbst_tap.sv
// Notes on behaviour
// - five rising test clocks with select high reach reset state, memory untouched.
// - power up resets the port; serial output starts undriven.
// - only one data register sits between serial in and out.
// - serial input sampled on rising test clock, output changes on falling.
// - instruction register is three bits, shifted serially when selected.
// - instruction register holds identification code after power up and reset state.
// - capture-instruction loads binary 01 into the two lowest bits.
// - one-bit bypass register captures low under bypass.
// - capture-data loads pin values into boundary register, then shifts it.
// - boundary register msb at serial input, lsb drives serial output.
// - identification instruction captures hardwired 32-bit value, then shifts it out.
// - new instruction takes effect only at update-instruction.
// - all-zero code samples like sample, but forces memory outputs undriven.
// - port never drives memory inputs nor preloads buffers; only captures.
// - sample-high-impedance selects boundary register and forces memory outputs undriven.
// - sample instruction snapshots all pin values without affecting memory.
// - bypass instruction puts bypass bit in the serial path.
// - codes 000,001,010,100,111 implemented; 011,101,110 reserved.
// - identification fields revision, depth, width, device, maker, constant one.
// - select sampled on rising test clock; floating select reads high. Here tms has no pull-up and goes straight into the synchronizer.
// - serial output driven only in shift states, undriven otherwise.
`timescale 1ns/10ps
`default_nettype none
module sbst_tap
  import sbst_pkg::*;
#(
  parameter int BSR_W = BSR_LEN,
  parameter logic [2:0] ID_REV = ID_REV_DEF,
  parameter logic [4:0] ID_DEPTH = ID_DEPTH_DEF,
  parameter logic [5:0] ID_WIDTH = ID_WIDTH_DEF,
  // device and maker codes: arbitrary values
  parameter logic [5:0] ID_DEV = ID_DEV_DEF,
  parameter logic [10:0] ID_MAKER = ID_MAKER_DEF
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo_o,
  output logic tdo_oe_n,
  input wire logic [BSR_W-1:0] pin_vals,
  output logic mem_out_hiz,
  input wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  // ==========================================================
  // helpers
  function automatic sbst_state_e fsm_next(input sbst_state_e s, input logic m);
    case (s)
      ST_TLR: fsm_next = m ? ST_TLR : ST_RTI;
      ST_RTI: fsm_next = m ? ST_SEL_DR : ST_RTI;
      ST_SEL_DR: fsm_next = m ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: fsm_next = m ? ST_EX1_DR : ST_SH_DR;
      ST_SH_DR: fsm_next = m ? ST_EX1_DR : ST_SH_DR;
      ST_EX1_DR: fsm_next = m ? ST_UPD_DR : ST_PA_DR;
      ST_PA_DR: fsm_next = m ? ST_EX2_DR : ST_PA_DR;
      ST_EX2_DR: fsm_next = m ? ST_UPD_DR : ST_SH_DR;
      ST_UPD_DR: fsm_next = m ? ST_SEL_DR : ST_RTI;
      ST_SEL_IR: fsm_next = m ? ST_TLR : ST_CAP_IR;
      ST_CAP_IR: fsm_next = m ? ST_EX1_IR : ST_SH_IR;
      ST_SH_IR: fsm_next = m ? ST_EX1_IR : ST_SH_IR;
      ST_EX1_IR: fsm_next = m ? ST_UPD_IR : ST_PA_IR;
      ST_PA_IR: fsm_next = m ? ST_EX2_IR : ST_PA_IR;
      ST_EX2_IR: fsm_next = m ? ST_UPD_IR : ST_SH_IR;
      ST_UPD_IR: fsm_next = m ? ST_SEL_DR : ST_RTI;
      default: fsm_next = ST_TLR;
    endcase
  endfunction : fsm_next

  function automatic logic uses_bsr(input logic [IR_W-1:0] ins);
    uses_bsr = (ins == INS_EXTEST) || (ins == INS_SAMPZ) || (ins == INS_SAMPLE);
  endfunction : uses_bsr

  function automatic logic addr_hit(input logic [AXI_ADDR_W-1:0] a,
                                    input logic [AXI_ADDR_W-1:0] off);
    addr_hit = (a[AXI_ADDR_W-1:2] == off[AXI_ADDR_W-1:2]);
  endfunction : addr_hit

  // ==========================================================
  // pin sampling and test clock edges
  logic [2:0] jt_s;
  logic tck_s;
  logic tms_s;
  logic tdi_s;
  logic [BSR_W-1:0] pins_s;
  logic tck_prev_q;
  logic tck_prev_d;
  logic tck_rise;
  logic tck_fall;

  sbst_sync #(.W(3)) u_sync_jtag (
    .clk(core_clk),
    .arst_n(arst_n),
    .din({tck, tms, tdi}),
    .dout(jt_s)
  );
  sbst_sync #(.W(BSR_W)) u_sync_pins (
    .clk(core_clk),
    .arst_n(arst_n),
    .din(pin_vals),
    .dout(pins_s)
  );
  assign tck_s = jt_s[2];
  assign tms_s = jt_s[1];
  assign tdi_s = jt_s[0];
  assign tck_prev_d = tck_s;
  assign tck_rise = tck_s && !tck_prev_q;
  assign tck_fall = !tck_s && tck_prev_q;

  // ==========================================================
  // controller state and instruction
  sbst_state_e state_q;
  sbst_state_e state_d;
  logic [IR_W-1:0] ir_q;
  logic [IR_W-1:0] ir_d;
  logic [IR_W-1:0] ir_sh;
  logic hold_q;

  always_comb begin
    state_d = state_q;
    ir_d = ir_q;
    if (tck_rise) begin
      state_d = fsm_next(state_q, tms_s);
      if (state_q == ST_UPD_IR) begin
        ir_d = ir_sh;
      end
    end
    if (state_q == ST_TLR) begin
      ir_d = INS_IDCODE;
    end
    if (hold_q) begin
      state_d = ST_TLR;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= ST_TLR;
      ir_q <= INS_IDCODE;
      tck_prev_q <= 1'b0;
    end else begin
      state_q <= state_d;
      ir_q <= ir_d;
      tck_prev_q <= tck_prev_d;
    end
  end

  // ==========================================================
  // scan registers
  logic cap_dr;
  logic sh_dr;
  logic [ID_W-1:0] id_val;
  logic [ID_W-1:0] id_sh;
  logic [BSR_W-1:0] bsr_sh;
  logic byp_q;
  logic byp_d;

  assign cap_dr = tck_rise && (state_q == ST_CAP_DR);
  assign sh_dr = tck_rise && (state_q == ST_SH_DR);
  assign id_val = {ID_REV, ID_DEPTH, ID_WIDTH, ID_DEV, ID_MAKER, ID_PRESENT};

  sbst_shreg #(.W(IR_W)) u_ir (
    .clk(core_clk),
    .arst_n(arst_n),
    .cap(tck_rise && (state_q == ST_CAP_IR)),
    .shift(tck_rise && (state_q == ST_SH_IR)),
    .cap_val(IR_CAP_VAL),
    .sin(tdi_s),
    .q(ir_sh)
  );
  sbst_shreg #(.W(ID_W)) u_id (
    .clk(core_clk),
    .arst_n(arst_n),
    .cap(cap_dr && (ir_q == INS_IDCODE)),
    .shift(sh_dr && (ir_q == INS_IDCODE)),
    .cap_val(id_val),
    .sin(tdi_s),
    .q(id_sh)
  );
  // capture only: no update stage feeds the pins
  sbst_shreg #(.W(BSR_W)) u_bsr (
    .clk(core_clk),
    .arst_n(arst_n),
    .cap(cap_dr && uses_bsr(ir_q)),
    .shift(sh_dr && uses_bsr(ir_q)),
    .cap_val(pins_s),
    .sin(tdi_s),
    .q(bsr_sh)
  );

  always_comb begin
    byp_d = byp_q;
    if (cap_dr && (ir_q != INS_IDCODE) && !uses_bsr(ir_q)) begin
      byp_d = 1'b0;
    end else if (sh_dr && (ir_q != INS_IDCODE) && !uses_bsr(ir_q)) begin
      byp_d = tdi_s;
    end
  end

  // ==========================================================
  // serial output on the falling edge
  logic tdo_q;
  logic tdo_d;
  logic oe_n_q;
  logic oe_n_d;
  logic hiz_q;
  logic hiz_d;

  always_comb begin
    tdo_d = tdo_q;
    oe_n_d = oe_n_q;
    if (tck_fall) begin
      oe_n_d = !((state_q == ST_SH_DR) || (state_q == ST_SH_IR));
      if (state_q == ST_SH_IR) begin
        tdo_d = ir_sh[0];
      end else if (ir_q == INS_IDCODE) begin
        tdo_d = id_sh[0];
      end else if (uses_bsr(ir_q)) begin
        tdo_d = bsr_sh[0];
      end else begin
        tdo_d = byp_q;
      end
    end
    hiz_d = (ir_q == INS_EXTEST) || (ir_q == INS_SAMPZ);
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      byp_q <= 1'b0;
      tdo_q <= 1'b0;
      oe_n_q <= 1'b1;
      hiz_q <= 1'b0;
    end else begin
      byp_q <= byp_d;
      tdo_q <= tdo_d;
      oe_n_q <= oe_n_d;
      hiz_q <= hiz_d;
    end
  end

  assign tdo_o = tdo_q;
  assign tdo_oe_n = oe_n_q;
  assign mem_out_hiz = hiz_q;

  // ==========================================================
  // register slave
  logic aw_got_q, aw_got_d, w_got_q, w_got_d, bvalid_q, bvalid_d;
  logic [AXI_ADDR_W-1:0] awaddr_q, awaddr_d;
  logic [31:0] wdata_q, wdata_d;
  logic wstrb0_q, wstrb0_d;
  logic [1:0] bresp_q, bresp_d;
  logic hold_d;
  logic rvalid_q, rvalid_d;
  logic [31:0] rdata_q, rdata_d;
  logic [1:0] rresp_q, rresp_d;

  assign s_axi_awready = !aw_got_q && !bvalid_q;
  assign s_axi_wready = !w_got_q && !bvalid_q;
  assign s_axi_arready = !rvalid_q;

  always_comb begin
    aw_got_d = aw_got_q;
    w_got_d = w_got_q;
    awaddr_d = awaddr_q;
    wdata_d = wdata_q;
    wstrb0_d = wstrb0_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    hold_d = hold_q;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_got_d = 1'b1;
      awaddr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_got_d = 1'b1;
      wdata_d = s_axi_wdata;
      wstrb0_d = s_axi_wstrb[0];
    end
    if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    if (aw_got_q && w_got_q && !bvalid_q) begin
      aw_got_d = 1'b0;
      w_got_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = RESP_OKAY;
      if (addr_hit(awaddr_q, REG_CTRL)) begin
        if (wstrb0_q) begin
          hold_d = wdata_q[CTRL_HOLD_BIT];
        end
      end else if (!addr_hit(awaddr_q, REG_STATUS) && !addr_hit(awaddr_q, REG_IDVAL)) begin
        bresp_d = RESP_SLVERR;
      end
    end
  end

  always_comb begin
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_d = 1'b1;
      rdata_d = '0;
      rresp_d = RESP_OKAY;
      if (addr_hit(s_axi_araddr, REG_CTRL)) begin
        rdata_d[CTRL_HOLD_BIT] = hold_q;
      end else if (addr_hit(s_axi_araddr, REG_STATUS)) begin
        rdata_d[STAT_STATE_LSB +: 4] = state_q;
        rdata_d[STAT_IR_LSB +: IR_W] = ir_q;
        rdata_d[STAT_HIZ_BIT] = hiz_q;
        rdata_d[STAT_DRIVE_BIT] = !oe_n_q;
      end else if (addr_hit(s_axi_araddr, REG_IDVAL)) begin
        rdata_d = id_val;
      end else begin
        rresp_d = RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb0_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      hold_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= RESP_OKAY;
    end else begin
      aw_got_q <= aw_got_d;
      w_got_q <= w_got_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      wstrb0_q <= wstrb0_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      hold_q <= hold_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // ==========================================================
  // checks
  logic [2:0] ones_q;
  logic [2:0] ones_d;
  localparam logic [2:0] ONES_MAX = 3'(TMS_RESET_RISES);

  always_comb begin
    ones_d = ones_q;
    if (tck_rise) begin
      ones_d = !tms_s ? 3'h0 : ((ones_q == ONES_MAX) ? ones_q : ones_q + 3'h1);
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ones_q <= 3'h0;
    end else begin
      ones_q <= ones_d;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  sequence s_cap_dr(logic [IR_W-1:0] ins);
    tck_rise && (state_q == ST_CAP_DR) && (ir_q == ins);
  endsequence
  sequence s_shift_fall;
    tck_fall && (state_q == ST_SH_DR);
  endsequence

  five_ones_a: assert property (ones_q == ONES_MAX |-> state_q == ST_TLR)
    else $error("five high select rises did not reach reset state");
  out_idle_a: assert property (tck_fall && (state_q != ST_SH_DR) && (state_q != ST_SH_IR)
    |=> oe_n_q)
    else $error("serial output driven outside shift states");
  out_edge_a: assert property ($changed(tdo_q) |-> $past(tck_fall))
    else $error("serial output changed away from a falling edge");
  ir_reset_a: assert property (state_q == ST_TLR |=> ir_q == INS_IDCODE)
    else $error("instruction not identification after reset state");
  ir_capture_a: assert property (tck_rise && state_q == ST_CAP_IR
    |=> ir_sh[1:0] == IR_CAP_PATTERN)
    else $error("capture pattern wrong");
  ir_update_a: assert property ($changed(ir_q) |-> $past(state_q == ST_TLR)
    || $past(tck_rise && state_q == ST_UPD_IR))
    else $error("instruction changed outside update");
  byp_capture_a: assert property (s_cap_dr(INS_BYPASS) |=> !byp_q)
    else $error("bypass bit not captured low");
  id_capture_a: assert property (s_cap_dr(INS_IDCODE) |=> id_sh == id_val)
    else $error("identification value not captured");
  bsr_capture_a: assert property (s_cap_dr(INS_SAMPLE) |=> bsr_sh == $past(pins_s))
    else $error("pin snapshot not captured");
  byp_path_a: assert property (s_shift_fall ##0 (ir_q == INS_BYPASS)
    |=> tdo_q == $past(byp_q))
    else $error("bypass bit not on serial output");
  hiz_force_a: assert property (ir_q == INS_EXTEST || ir_q == INS_SAMPZ
    |=> ##[0:1] mem_out_hiz)
    else $error("memory outputs not forced undriven");
endmodule : sbst_tap
`default_nettype wire

// File: verification/sbst_ctl_model.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// external scan controller
module sbst_ctl_model (
  input wire logic core_clk,
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo_o,
  input wire logic tdo_oe_n
);
  // clock parked low, select and data at pull-up level
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
  end
  // one test clock of 8 core cycles, 400 ns
  task automatic pulse(input logic m, input logic d, output logic o);
    tck <= 1'b0;
    tms <= m;
    tdi <= d;
    repeat (4) @(posedge core_clk);
    tck <= 1'b1;
    repeat (4) @(posedge core_clk);
    o = tdo_oe_n ? 1'bz : tdo_o;
  endtask : pulse
  // select sequence, lsb first
  task automatic walk(input logic [7:0] seq, input int n);
    logic o;
    for (int i = 0; i < n; i++) begin
      pulse(seq[i], 1'b1, o);
    end
  endtask : walk
  // shift n bits, leaves the port in exit1
  task automatic shift(input logic [159:0] din, input int n, output logic [159:0] dout);
    logic o;
    dout = '0;
    for (int i = 0; i < n; i++) begin
      pulse(i == n - 1, din[i], o);
      dout[i] = o;
    end
  endtask : shift
  task automatic reset5();
    logic o;
    repeat (5) pulse(1'b1, 1'b1, o);
  endtask : reset5
  task automatic park();
    tck <= 1'b0;
    tdi <= 1'b1;
    repeat (4) @(posedge core_clk);
  endtask : park
endmodule : sbst_ctl_model
`default_nettype wire

// File: verification/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
  import sbst_pkg::*;
  logic core_clk, arst_n, tck, tms, tdi, tdo_o, tdo_oe_n, mem_out_hiz;
  logic [BSR_LEN-1:0] pin_vals;
  logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int mismatches, n_compared, cycles;
  logic [159:0] din, o;
  logic [31:0] v;
  logic [1:0] r;
  logic [2:0] codes [3] = '{INS_EXTEST, INS_SAMPZ, INS_SAMPLE};

  sbst_tap sbst_tap_i (.core_clk, .arst_n, .tck, .tms, .tdi, .tdo_o, .tdo_oe_n, .pin_vals,
    .mem_out_hiz, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  sbst_ctl_model sbst_ctl_model_i (.core_clk, .tck, .tms, .tdi, .tdo_o, .tdo_oe_n);

  initial core_clk = 1'b0;
  always #25 core_clk = ~core_clk;

  // ==========================================
  // helpers
  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_of_test
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      end_of_test();
    end
  end
  task automatic chk(input string what, input logic [159:0] exp, input logic [159:0] got);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  function automatic logic [159:0] rnd();
    return {$urandom, $urandom, $urandom, $urandom, $urandom};
  endfunction : rnd
  function automatic logic [31:0] exp_id();
    return {ID_REV_DEF, ID_DEPTH_DEF, ID_WIDTH_DEF, ID_DEV_DEF, ID_MAKER_DEF, ID_PRESENT};
  endfunction : exp_id
  task automatic axw(input logic [3:0] a, input logic [31:0] d, output logic [1:0] rs);
    bit aw_ok, w_ok;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge core_clk);
      if (!aw_ok && s_axi_awready) begin
        aw_ok = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_ok && s_axi_wready) begin
        w_ok = 1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge core_clk); while (s_axi_bvalid !== 1'b1);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge core_clk);
  endtask : axw
  task automatic axr(input logic [3:0] a, output logic [31:0] d, output logic [1:0] rs);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge core_clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge core_clk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge core_clk);
  endtask : axr
  // load an instruction from idle, checking capture and update timing
  task automatic load(input logic [2:0] code);
    logic [2:0] old;
    axr(REG_STATUS, v, r);
    old = v[6:4];
    sbst_ctl_model_i.walk(8'h03, 4);
    sbst_ctl_model_i.shift(160'(code), 3, o);
    chk("ir capture", 160'(IR_CAP_PATTERN), 160'(o[1:0]));
    axr(REG_STATUS, v, r);
    chk("ir before update", 160'(old), 160'(v[6:4]));
    sbst_ctl_model_i.walk(8'h01, 2);
    axr(REG_STATUS, v, r);
    chk("ir after update", 160'(code), 160'(v[6:4]));
  endtask : load

  // ==========================================
  // sequence
  initial begin
    arst_n = 1'b0;
    pin_vals = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    void'($urandom(47));
    repeat (16) @(posedge core_clk);
    arst_n <= 1'b1;
    @(posedge core_clk);
    chk("oe_n at power up", 160'(1'b1), 160'(tdo_oe_n));
    axr(REG_STATUS, v, r);
    chk("state at power up", 160'(ST_TLR), 160'(v[3:0]));
    chk("ir at power up", 160'(INS_IDCODE), 160'(v[6:4]));
    axr(REG_IDVAL, v, r);
    chk("idval", 160'(exp_id()), 160'(v));
    chk("idval resp", 160'(RESP_OKAY), 160'(r));
    sbst_ctl_model_i.walk(8'h02, 4);
    din = rnd();
    sbst_ctl_model_i.shift(din, ID_W, o);
    chk("id shift", 160'(exp_id()), o);
    sbst_ctl_model_i.walk(8'h01, 2);
    sbst_ctl_model_i.park();
    chk("oe_n idle", 160'(1'b1), 160'(tdo_oe_n));
    $display("test identification done");
    load(INS_BYPASS);
    sbst_ctl_model_i.walk(8'h01, 3);
    din = rnd();
    sbst_ctl_model_i.shift(din, 20, o);
    chk("bypass path", 160'({din[18:0], 1'b0}), o);
    sbst_ctl_model_i.walk(8'h01, 2);
    chk("hiz bypass", 160'(1'b0), 160'(mem_out_hiz));
    $display("test bypass done");
    sbst_ctl_model_i.walk(8'h01, 3);
    sbst_ctl_model_i.reset5();
    axr(REG_STATUS, v, r);
    chk("state after reset", 160'(ST_TLR), 160'(v[3:0]));
    chk("ir after reset", 160'(INS_IDCODE), 160'(v[6:4]));
    sbst_ctl_model_i.walk(8'h00, 1);
    $display("test reset done");
    foreach (codes[k]) begin
      // pins settle well before capture
      pin_vals <= BSR_LEN'(rnd());
      load(codes[k]);
      chk("hiz", 160'(codes[k] != INS_SAMPLE), 160'(mem_out_hiz));
      sbst_ctl_model_i.walk(8'h01, 3);
      din = rnd();
      sbst_ctl_model_i.shift(din, 2 * BSR_LEN, o);
      chk("bsr capture", 160'(pin_vals), 160'(o[BSR_LEN-1:0]));
      chk("bsr pass", 160'(din[BSR_LEN-1:0]), 160'(o[2*BSR_LEN-1:BSR_LEN]));
      sbst_ctl_model_i.walk(8'h01, 2);
      $display("test boundary code %0d done", codes[k]);
    end
    axw(REG_CTRL, 32'h1, r);
    chk("ctrl resp", 160'(RESP_OKAY), 160'(r));
    axr(REG_STATUS, v, r);
    chk("state held", 160'(ST_TLR), 160'(v[3:0]));
    axw(REG_CTRL, 32'h0, r);
    axw(4'hc, 32'h1, r);
    chk("unmapped write", 160'(RESP_SLVERR), 160'(r));
    axr(4'hc, v, r);
    chk("unmapped read", 160'(RESP_SLVERR), 160'(r));
    $display("test registers done");
    end_of_test();
  end
endmodule : tb
`default_nettype wire
